// ==== rfs_frontend.sv ====
// Overview of operation
// - Test field value 111 puts the radio into automatic PA/LNA mode.
// - In PA/LNA mode the PA and LNA switch pins follow transmit and receive.
// - Regulator level bit 1 drives the pin high, powering the PA supply.
// - Regulator level bit 0 drives the pin low, shutting the PA supply.
// - Reported signal strength includes the LNA gain.
// - Transmit power code sits in bits 7:3 of rf_control_three.
// - Host link is 4-wire serial plus interrupt, wake and reset.
module rfs_frontend import rfs_pkg::*; #(
  parameter logic [7:0] LNA_GAIN = 8'h0c
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_sck_in,
  input wire logic spi_sdi_in,
  output logic spi_sdo_out,
  output logic spi_sdo_oe_n_out,
  input wire logic wake_in,
  input wire logic irq_in,
  output logic int_out,
  output logic wake_req_out,
  input wire logic tx_active_in,
  input wire logic rx_active_in,
  input wire logic [7:0] rssi_raw_in,
  output logic [7:0] rssi_report_out,
  output logic [4:0] tx_power_code_out,
  output rfs_pin_t pa_switch_pin_out,
  output rfs_pin_t lna_switch_pin_out,
  output rfs_pin_t pa_regulator_pin_out
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [3:0] pins_s;
  logic cs_n_s;
  logic sck_s;
  logic sdi_s;
  logic wake_s;

  // Select resets high: a low value would look like a frame start
  rfs_sync #(.W(4), .RST_VAL(4'h8)) u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .d_in({spi_cs_n_in, spi_sck_in, spi_sdi_in, wake_in}),
    .q_out(pins_s)
  );

  assign cs_n_s = pins_s[3];
  assign sck_s = pins_s[2];
  assign sdi_s = pins_s[1];
  assign wake_s = pins_s[0];

  ////////////////////////////////////////////////////////////////////////
  // Register storage and read decode

  logic [7:0] gpio_level_r;
  logic [7:0] gpio_direction_r;
  logic [7:0] rf_control_three_r;
  logic [7:0] rf_test_control_r;

  // Unmapped addresses read as zero
  function automatic logic [7:0] reg_read(input logic [9:0] addr);
    case (addr)
      GPIO_LEVEL_ADDR: reg_read = gpio_level_r;
      GPIO_DIR_ADDR: reg_read = gpio_direction_r;
      RF_CTRL3_ADDR: reg_read = rf_control_three_r;
      RF_TEST_ADDR: reg_read = rf_test_control_r;
      default: reg_read = 8'h00;
    endcase
  endfunction : reg_read

  ////////////////////////////////////////////////////////////////////////
  // Serial slave, oversampled from the system clock

  rfs_spi_state_t state_r;
  logic sck_d_r;
  logic [4:0] cnt_r;
  logic [23:0] sh_r;
  logic [9:0] addr_r;
  logic wr_r;
  logic long_r;
  logic [7:0] tx_r;
  logic wr_stb_r;
  logic [7:0] wr_data_r;
  logic sck_rise;
  logic sck_fall;
  logic [23:0] sh_nxt;
  logic [4:0] cnt_nxt;

  assign sck_rise = sck_s & ~sck_d_r;
  assign sck_fall = ~sck_s & sck_d_r;
  assign sh_nxt = {sh_r[22:0], sdi_s};
  assign cnt_nxt = cnt_r + 5'h01;

  // Edge history of the serial clock
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sck_d_r <= 1'b0;
    end else begin
      sck_d_r <= sck_s;
    end
  end

  // Frame decoder; short frame 16 bits, long frame 24 bits
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= ST_CMD;
      cnt_r <= 5'h00;
      sh_r <= 24'h000000;
      addr_r <= 10'h000;
      wr_r <= 1'b0;
      long_r <= 1'b0;
      tx_r <= 8'h00;
      wr_stb_r <= 1'b0;
      wr_data_r <= 8'h00;
      spi_sdo_out <= 1'b0;
    end else begin
      wr_stb_r <= 1'b0;
      if (cs_n_s) begin
        state_r <= ST_CMD;
        cnt_r <= 5'h00;
      end else if (sck_rise) begin
        sh_r <= sh_nxt;
        cnt_r <= cnt_nxt;
        case (state_r)
          ST_CMD: begin
            if (cnt_nxt == CMD_BITS) begin
              if (!sh_nxt[7]) begin
                addr_r <= {4'h0, sh_nxt[6:1]};
                wr_r <= sh_nxt[0];
                long_r <= 1'b0;
                tx_r <= reg_read({4'h0, sh_nxt[6:1]});
                state_r <= ST_DATA;
              end else begin
                long_r <= 1'b1;
                state_r <= ST_LADDR;
              end
            end
          end
          ST_LADDR: begin
            if (cnt_nxt == LONG_HDR_BITS) begin
              addr_r <= sh_nxt[10:1];
              wr_r <= sh_nxt[0];
            end
            // Four filler bits pass before the data byte
            if (cnt_nxt == LONG_DATA_START) begin
              tx_r <= reg_read(addr_r);
              state_r <= ST_DATA;
            end
          end
          ST_DATA: begin
            if (cnt_nxt == (long_r ? LONG_END : SHORT_END)) begin
              wr_stb_r <= wr_r;
              wr_data_r <= sh_nxt[7:0];
              state_r <= ST_DONE;
            end
          end
          ST_DONE: begin
            cnt_r <= cnt_r; // Extra bits ignored until deselect
          end
          default: state_r <= ST_CMD;
        endcase
      end else if (sck_fall && state_r == ST_DATA) begin
        spi_sdo_out <= tx_r[7];
        tx_r <= {tx_r[6:0], 1'b0};
      end
    end
  end

  // Data line released whenever the link is deselected
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      spi_sdo_oe_n_out <= 1'b1;
    end else begin
      spi_sdo_oe_n_out <= cs_n_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register writes, applied one whole frame at a time

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gpio_level_r <= GPIO_LEVEL_RST;
      gpio_direction_r <= GPIO_DIR_RST;
      rf_control_three_r <= RF_CTRL3_RST;
      rf_test_control_r <= RF_TEST_RST;
    end else if (wr_stb_r) begin
      case (addr_r)
        GPIO_LEVEL_ADDR: gpio_level_r <= wr_data_r;
        GPIO_DIR_ADDR: gpio_direction_r <= wr_data_r;
        RF_CTRL3_ADDR: rf_control_three_r <= wr_data_r;
        RF_TEST_ADDR: rf_test_control_r <= wr_data_r;
        default: gpio_level_r <= gpio_level_r;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Front-end pin drive

  logic palna_mode;

  assign palna_mode = (rf_test_control_r[TEST_MSB:TEST_LSB] == TEST_PALNA);

  // Automatic mode overrides the direction bits on the two switch pins
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pa_switch_pin_out <= '{level: 1'b0, oe_n: 1'b1};
      lna_switch_pin_out <= '{level: 1'b0, oe_n: 1'b1};
    end else if (palna_mode) begin
      pa_switch_pin_out <= '{level: tx_active_in, oe_n: 1'b0};
      lna_switch_pin_out <= '{level: rx_active_in, oe_n: 1'b0};
    end else begin
      pa_switch_pin_out <= '{level: gpio_level_r[PA_SWITCH_BIT],
                             oe_n: ~gpio_direction_r[PA_SWITCH_BIT]};
      lna_switch_pin_out <= '{level: gpio_level_r[LNA_SWITCH_BIT],
                              oe_n: ~gpio_direction_r[LNA_SWITCH_BIT]};
    end
  end

  // Regulator pin is always software-owned; floats until direction set
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pa_regulator_pin_out <= '{level: 1'b0, oe_n: 1'b1};
    end else begin
      pa_regulator_pin_out <= '{level: gpio_level_r[PA_REG_BIT],
                                oe_n: ~gpio_direction_r[PA_REG_BIT]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status outputs

  logic [8:0] rssi_sum;

  assign rssi_sum = {1'b0, rssi_raw_in} + {1'b0, LNA_GAIN};

  // Saturate rather than wrap so a strong signal never reads as weak
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rssi_report_out <= 8'h00;
    end else begin
      rssi_report_out <= rssi_sum[8] ? 8'hff : rssi_sum[7:0];
    end
  end

  // Power code, interrupt and wake forwarding
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_power_code_out <= 5'h00;
      int_out <= 1'b0;
      wake_req_out <= 1'b0;
    end else begin
      tx_power_code_out <= rf_control_three_r[TXPWR_MSB:TXPWR_LSB];
      int_out <= irq_in;
      wake_req_out <= wake_s;
    end
  end

endmodule : rfs_frontend

// ==== rfs_frontend_monitor.sv ====
module rfs_frontend_monitor import rfs_pkg::*; #(
  parameter logic [7:0] LNA_GAIN = 8'h0c
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_sdo_oe_n_out,
  input wire logic wake_in,
  input wire logic irq_in,
  input wire logic int_out,
  input wire logic wake_req_out,
  input wire logic tx_active_in,
  input wire logic rx_active_in,
  input wire logic [7:0] rssi_raw_in,
  input wire logic [7:0] rssi_report_out,
  input wire logic [4:0] tx_power_code_out,
  input wire rfs_pin_t pa_switch_pin_out,
  input wire rfs_pin_t lna_switch_pin_out,
  input wire rfs_pin_t pa_regulator_pin_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  ////////////////////////////////////////
  // Saturating sum, a wrap would look like a weak signal
  function automatic logic [7:0] gain_f(input logic [7:0] r);
    logic [8:0] s;
    s = {1'b0, r} + {1'b0, LNA_GAIN};
    return s[8] ? 8'hff : s[7:0];
  endfunction : gain_f
  // Link idle long enough for any write to have landed
  sequence quiet_s;
    spi_cs_n_in [*6];
  endsequence
  sequence still_s;
    ($stable(tx_active_in) && $stable(rx_active_in)) [*2];
  endsequence
  ////////////////////////////////////////
  int_copy_a: assert property ($past(rst_n_in) |-> int_out == $past(irq_in))
    else $error("int_out not one cycle behind irq_in");
  wake_sync_a: assert property ($rose(wake_in) |-> ##[1:4] wake_req_out)
    else $error("wake request late");
  rssi_gain_a: assert property ($past(rst_n_in) |-> rssi_report_out == gain_f($past(rssi_raw_in)))
    else $error("rssi report lacks amplifier gain");
  oe_release_a: assert property (spi_cs_n_in [*4] |-> spi_sdo_oe_n_out)
    else $error("sdo driven while deselected");
  oe_drive_a: assert property (!spi_cs_n_in [*4] |-> !spi_sdo_oe_n_out)
    else $error("sdo not driven while selected");
  txpwr_hold_a: assert property (quiet_s |-> $stable(tx_power_code_out))
    else $error("tx power changed without a write");
  reg_hold_a: assert property (quiet_s |-> $stable(pa_regulator_pin_out))
    else $error("regulator pin changed without a write");
  switch_hold_a: assert property (quiet_s ##0 still_s |->
    $stable(pa_switch_pin_out) && $stable(lna_switch_pin_out))
    else $error("switch pins moved with no cause");
endmodule : rfs_frontend_monitor

bind rfs_frontend rfs_frontend_monitor #(.LNA_GAIN(LNA_GAIN))
  i_rfs_frontend_monitor (.*);

// ==== rfs_frontend_test.sv ====
module rfs_frontend_test import rfs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_in, rst_n_in, spi_cs_n_in, spi_sck_in, spi_sdi_in, wake_in, irq_in;
  logic tx_active_in, rx_active_in, spi_sdo_out, spi_sdo_oe_n_out, int_out, wake_req_out;
  logic [7:0] rssi_raw_in, rssi_report_out, rd;
  logic [4:0] tx_power_code_out;
  rfs_pin_t pa_switch_pin_out, lna_switch_pin_out, pa_regulator_pin_out;
  logic [9:0] adr [4] = '{GPIO_LEVEL_ADDR, GPIO_DIR_ADDR, RF_CTRL3_ADDR, RF_TEST_ADDR};
  logic [4:0] codes [3] = '{5'h05, 5'h1f, 5'h0a};
  int n_errors = 0;
  int cmp_count = 0;

  rfs_frontend #(.LNA_GAIN(8'h0c)) i_rfs_frontend (.*);
  rfs_host i_rfs_host (.clk_sys_in(clk_sys_in), .sdo_in(spi_sdo_out),
    .sdo_oe_n_in(spi_sdo_oe_n_out), .cs_n_out(spi_cs_n_in), .sck_out(spi_sck_in),
    .sdi_out(spi_sdi_in));
  ////////////////////////////////////////
  // 10 MHz system clock
  initial begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    i_rfs_host.xfer(a, 1'b1, d, rd);
  endtask : wr
  task automatic rdc(input logic [9:0] a, input logic [7:0] exp);
    i_rfs_host.xfer(a, 1'b0, 8'h00, rd);
    chk("readback", exp, rd);
  endtask : rdc
  // Each pin given as {level, oe_n}
  task automatic pins(input logic [1:0] pa, input logic [1:0] lna, input logic [1:0] rg);
    chk("pa pin", {6'h00, pa}, {6'h00, pa_switch_pin_out});
    chk("lna pin", {6'h00, lna}, {6'h00, lna_switch_pin_out});
    chk("regulator pin", {6'h00, rg}, {6'h00, pa_regulator_pin_out});
  endtask : pins
  task automatic give_verdict();
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////
  // Hang guard
  initial begin
    repeat (50000) @(posedge clk_sys_in);
    n_errors++;
    give_verdict();
  end
  // Main sequence
  initial begin
    {rst_n_in, wake_in, irq_in, tx_active_in, rx_active_in} = 5'h00;
    rssi_raw_in = 8'h00;
    repeat (10) @(posedge clk_sys_in);
    #1 rst_n_in = 1'b1;
    i_rfs_host.tick(3);
    pins(2'h1, 2'h1, 2'h1);
    for (int i = 0; i < 4; i++) rdc(adr[i], 8'h00);
    wr(10'h100, 8'h5a);
    rdc(10'h100, 8'h00);
    wr(GPIO_DIR_ADDR, 8'h08);
    wr(GPIO_LEVEL_ADDR, 8'h08);
    pins(2'h1, 2'h1, 2'h2);
    wr(GPIO_LEVEL_ADDR, 8'h00);
    pins(2'h1, 2'h1, 2'h0);
    wr(RF_TEST_ADDR, 8'h07);
    tx_active_in = 1'b1;
    i_rfs_host.tick(2);
    pins(2'h2, 2'h0, 2'h0);
    {tx_active_in, rx_active_in} = 2'h1;
    i_rfs_host.tick(2);
    pins(2'h0, 2'h2, 2'h0);
    // Transmit busy: manual levels must still win
    {tx_active_in, rx_active_in} = 2'h2;
    wr(RF_TEST_ADDR, 8'h00);
    wr(GPIO_DIR_ADDR, 8'h0e);
    wr(GPIO_LEVEL_ADDR, 8'h0c);
    pins(2'h0, 2'h2, 2'h2);
    rssi_raw_in = 8'h10;
    i_rfs_host.tick(2);
    chk("rssi", 8'h1c, rssi_report_out);
    rssi_raw_in = 8'hf8;
    i_rfs_host.tick(2);
    chk("rssi", 8'hff, rssi_report_out);
    // Gain added across the range below saturation
    for (int k = 0; k < 4; k++) begin
      rssi_raw_in = 8'(k) * 8'h3d;
      i_rfs_host.tick(2);
      chk("rssi", 8'(rssi_raw_in + 8'h0c), rssi_report_out);
    end
    wr(GPIO_LEVEL_ADDR, 8'h08);
    pins(2'h0, 2'h0, 2'h2);
    wr(GPIO_LEVEL_ADDR, 8'h00);
    pins(2'h0, 2'h0, 2'h0);
    wake_in = 1'b1;
    for (int i = 0; i < 8 && wake_req_out !== 1'b1; i++) i_rfs_host.tick(1);
    chk("wake", 8'h01, {7'h00, wake_req_out});
    wr(RF_TEST_ADDR, 8'h07);
    pins(2'h2, 2'h0, 2'h0);
    // Every transmit and receive combination in automatic mode
    for (int k = 0; k < 4; k++) begin
      {tx_active_in, rx_active_in} = 2'(k);
      i_rfs_host.tick(2);
      pins({k[1], 1'b0}, {k[0], 1'b0}, 2'h0);
    end
    for (int i = 0; i < 3; i++) begin
      wr(RF_CTRL3_ADDR, {codes[i], 3'h5});
      chk("tx power", {3'h0, codes[i]}, {3'h0, tx_power_code_out});
      rdc(RF_CTRL3_ADDR, {codes[i], 3'h5});
    end
    // Interrupt must follow the core in both directions
    for (int k = 0; k < 4; k++) begin
      irq_in = k[0];
      i_rfs_host.tick(2);
      chk("int", {7'h00, k[0]}, {7'h00, int_out});
    end
    wake_in = 1'b0;
    for (int i = 0; i < 8 && wake_req_out !== 1'b0; i++) i_rfs_host.tick(1);
    chk("wake", 8'h00, {7'h00, wake_req_out});
    // Second reset in mid-run must restore every register and pin
    rst_n_in = 1'b0;
    i_rfs_host.tick(3);
    rst_n_in = 1'b1;
    i_rfs_host.tick(3);
    pins(2'h1, 2'h1, 2'h1);
    chk("tx power", 8'h00, {3'h0, tx_power_code_out});
    for (int i = 0; i < 4; i++) rdc(adr[i], 8'h00);
    give_verdict();
  end
endmodule : rfs_frontend_test

// ==== rfs_host.sv ====
module rfs_host (
  input wire logic clk_sys_in,
  input wire logic sdo_in,
  input wire logic sdo_oe_n_in,
  output logic cs_n_out,
  output logic sck_out,
  output logic sdi_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle link: select high, clock parked low
  initial begin
    cs_n_out = 1'b1;
    sck_out = 1'b0;
    sdi_out = 1'b0;
  end
  ////////////////////////////////////////
  // Waits end just after an edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask : tick
  // Whole frame, 800 ns per bit; low phase long for the sdo delay
  task automatic xfer(input logic [9:0] a, input logic wr, input logic [7:0] wd,
                      output logic [7:0] rd);
    logic [23:0] f;
    int n;
    n = a > 10'h03f ? 24 : 16;
    f = n == 24 ? {1'b1, a, wr, 4'h0, wd} : {1'b0, a[5:0], wr, wd, 8'h00};
    rd = 8'h00;
    tick(1);
    cs_n_out = 1'b0;
    for (int i = 0; i < n; i++) begin
      sdi_out = f[23-i];
      tick(5);
      // Released line shows the inverse so a stale bit never passes
      rd = {rd[6:0], sdo_oe_n_in ? ~sdo_in : sdo_in};
      sck_out = 1'b1;
      tick(3);
      sck_out = 1'b0;
    end
    tick(5);
    cs_n_out = 1'b1;
    // Released data line flips so stale bits never pass
    sdi_out = ~sdi_out;
    tick(4);
  endtask : xfer
endmodule : rfs_host

// ==== rfs_pkg.sv ====
package rfs_pkg;

  // Register addresses on the serial link (short ones zero-extended)
  localparam logic [9:0] GPIO_LEVEL_ADDR = 10'h033;
  localparam logic [9:0] GPIO_DIR_ADDR = 10'h034;
  localparam logic [9:0] RF_CTRL3_ADDR = 10'h203;
  localparam logic [9:0] RF_TEST_ADDR = 10'h22f;

  // Reset values of the four registers
  localparam logic [7:0] GPIO_LEVEL_RST = 8'h00;
  localparam logic [7:0] GPIO_DIR_RST = 8'h00;
  localparam logic [7:0] RF_CTRL3_RST = 8'h00;
  localparam logic [7:0] RF_TEST_RST = 8'h00;

  // Field positions
  localparam int PA_SWITCH_BIT = 1;
  localparam int LNA_SWITCH_BIT = 2;
  localparam int PA_REG_BIT = 3;
  localparam int TEST_MSB = 2;
  localparam int TEST_LSB = 0;
  localparam int TXPWR_MSB = 7;
  localparam int TXPWR_LSB = 3;

  // Test field encodings
  localparam logic [2:0] TEST_PALNA = 3'h7;
  localparam logic [2:0] TEST_NORMAL = 3'h0;

  // Serial frame bit counts
  localparam logic [4:0] CMD_BITS = 5'h08;
  localparam logic [4:0] LONG_HDR_BITS = 5'h0c;
  localparam logic [4:0] LONG_DATA_START = 5'h10;
  localparam logic [4:0] SHORT_END = 5'h10;
  localparam logic [4:0] LONG_END = 5'h18;

  typedef enum logic [1:0] {
    ST_CMD = 2'b00,
    ST_LADDR = 2'b01,
    ST_DATA = 2'b10,
    ST_DONE = 2'b11
  } rfs_spi_state_t;

  // A two-way pin: level and active-low output enable
  typedef struct packed {
    logic level;
    logic oe_n;
  } rfs_pin_t;

endpackage : rfs_pkg

// ==== rfs_sync.sv ====
module rfs_sync import rfs_pkg::*; #(
  parameter int W = 1,
  // Idle level of each pin, so reset release shows no false edge
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  logic [W-1:0] meta_r;

  initial begin
    if (W < 1) begin
      $error("rfs_sync: width must be at least 1");
    end
  end

  // Two flops; the first feeds only the second
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_r <= RST_VAL;
      q_out <= RST_VAL;
    end else begin
      meta_r <= d_in;
      q_out <= meta_r;
    end
  end

endmodule : rfs_sync
